// [shared/shpr_pkg.sv]
`default_nettype none

package shpr_pkg;

    // register byte offsets
    localparam logic [5:0] REG_CTRL = 6'h00;  // command start
    localparam logic [5:0] REG_REQ  = 6'h04;  // command class, parameter, length
    localparam logic [5:0] REG_SUB  = 6'h08;  // request subunit_selector
    localparam logic [5:0] REG_DATA = 6'h0C;  // request parameter data
    localparam logic [5:0] REG_STAT = 6'h10;  // busy, done, nack, reply length
    localparam logic [5:0] REG_RSUB = 6'h14;  // echoed selector, message count
    localparam logic [5:0] REG_RD0  = 6'h18;  // sensor number, capability
    localparam logic [5:0] REG_RD1  = 6'h1C;  // present/lowest or hours
    localparam logic [5:0] REG_RD2  = 6'h20;  // highest/recorded

    // field positions
    localparam int CTRL_START_BIT  = 0;
    localparam int REQ_SET_BIT     = 0;   // 0 get, 1 set
    localparam int REQ_SEL_LSB     = 8;   // two-bit parameter select
    localparam int REQ_LEN_LSB     = 16;  // param_data_length
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DONE_BIT   = 1;
    localparam int STAT_NACK_BIT   = 2;
    localparam int STAT_REASON_LSB = 8;
    localparam int STAT_LEN_LSB    = 16;
    localparam int RSUB_COUNT_LSB  = 16;
    localparam int RD0_CAP_LSB     = 8;
    localparam int CAP_RECORD_BIT  = 0;
    localparam int CAP_MINMAX_BIT  = 1;

    // reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic        WAIT_RST = 1'b1;

    // lengths, codes and limits
    localparam logic [7:0]  LEN_ONE        = 8'h01;
    localparam logic [7:0]  LEN_SENSOR_RSP = 8'h09;
    localparam logic [7:0]  LEN_HOURS      = 8'h04;
    localparam logic [7:0]  LEN_EMPTY      = 8'h00;
    localparam logic [7:0]  SENSOR_ALL     = 8'hFF;
    localparam logic [7:0]  MSG_COUNT      = 8'h00;
    localparam logic [31:0] HOURS_MAX      = 32'hFFFF_FFFF;
    localparam logic [7:0]  NACK_NONE      = 8'h00;
    localparam logic [7:0]  NACK_RANGE     = 8'h01;
    localparam logic [7:0]  NACK_FORMAT    = 8'h02;
    localparam logic [7:0]  NACK_UNSUPP    = 8'h03;

    // parameter select codes
    typedef enum logic [1:0] {
        SHPR_SEL_SENSOR,
        SHPR_SEL_RECORD,
        SHPR_SEL_HOURS,
        SHPR_SEL_NONE
    } shpr_sel_t;

    // one sensor's tracked readings
    typedef struct packed {
        logic signed [15:0] present;
        logic signed [15:0] lowest;
        logic signed [15:0] highest;
        logic signed [15:0] recorded;
    } shpr_reading_t;

endpackage : shpr_pkg

`default_nettype wire

// [core/shpr_sensor_track.sv]
`timescale 1ns/1ps
`default_nettype none

module shpr_sensor_track #(
    parameter bit HAS_MINMAX = 1'b1,
    parameter bit HAS_RECORD = 1'b1
) (
    input  wire logic                  core_clk,
    input  wire logic                  rstn,
    input  wire logic signed [15:0]    sample,
    input  wire logic                  sample_valid,
    input  wire logic                  clear,
    input  wire logic                  record,
    output shpr_pkg::shpr_reading_t    reading
);

    logic signed [15:0] cur_reg, cur_next;  // present value
    logic signed [15:0] lo_reg,  lo_next;   // lowest seen
    logic signed [15:0] hi_reg,  hi_next;   // highest seen
    logic signed [15:0] rec_reg, rec_next;  // snapshot
    logic               seen_reg, seen_next; // min/max hold a real sample

    // next readings
    always_comb begin
        cur_next  = cur_reg;
        lo_next   = lo_reg;
        hi_next   = hi_reg;
        rec_next  = rec_reg;
        seen_next = seen_reg;
        if (clear) begin
            // lowest, highest and recorded collapse onto present (zero if their feature is off); clear beats a new sample
            lo_next   = HAS_MINMAX ? cur_reg : 16'sh0000;
            hi_next   = HAS_MINMAX ? cur_reg : 16'sh0000;
            rec_next  = HAS_RECORD ? cur_reg : 16'sh0000;
            seen_next = 1'b1;
        end else begin
            if (sample_valid) begin
                cur_next  = sample;
                seen_next = 1'b1;
                if (HAS_MINMAX && (!seen_reg || sample < lo_reg)) begin
                    lo_next = sample;
                end
                if (HAS_MINMAX && (!seen_reg || sample > hi_reg)) begin
                    hi_next = sample;
                end
            end
            if (record && HAS_RECORD) begin
                rec_next = cur_reg;
            end
        end
    end

    // register readings
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur_reg  <= 16'sh0000;
            lo_reg   <= 16'sh0000;
            hi_reg   <= 16'sh0000;
            rec_reg  <= 16'sh0000;
            seen_reg <= 1'b0;
        end else begin
            cur_reg  <= cur_next;
            lo_reg   <= lo_next;
            hi_reg   <= hi_next;
            rec_reg  <= rec_next;
            seen_reg <= seen_next;
        end
    end

    assign reading = '{present: cur_reg, lowest: lo_reg, highest: hi_reg, recorded: rec_reg};

endmodule : shpr_sensor_track

`default_nettype wire

// [core/shpr_responder.sv]
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module shpr_responder #(
    parameter int NUM_SENSORS   = 4,
    parameter bit HAS_MINMAX    = 1'b1,
    parameter bit HAS_RECORD    = 1'b1,
    parameter bit HAS_HOURS_SET = 1'b1
) (
    input  wire logic                      core_clk,
    input  wire logic                      rstn,
    input  wire logic [5:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic      [31:0]               avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic [NUM_SENSORS*16-1:0] sensor_sample,
    input  wire logic [NUM_SENSORS-1:0]    sensor_sample_valid,
    input  wire logic                      hour_tick
);

    // elaboration check on sensor count
    if (NUM_SENSORS < 1 || NUM_SENSORS > 255) begin : g_bad_count
        $error("NUM_SENSORS must lie in 1..255");
    end

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_REPLY
    } shpr_state_t;

    // bus side
    logic        wait_reg, wait_next;        // waitrequest flop
    logic [31:0] rdata_reg, rdata_next;      // readdata flop
    logic        wr_acc;                     // write taken this edge
    logic [31:0] rd_mux;                     // register read value

    // request registers
    logic [31:0] req_reg,  req_next;         // class, select, length
    logic [31:0] sub_reg,  sub_next;         // subunit_selector
    logic [31:0] data_reg, data_next;        // parameter data
    logic        start;                      // accepted start write

    // command engine
    shpr_state_t st_reg, st_next;            // engine state
    logic        done_reg, done_next;        // sticky completion
    logic        nack_reg, nack_next;        // negative reply
    logic [7:0]  reason_reg, reason_next;    // nack cause
    logic [7:0]  rlen_reg, rlen_next;        // reply param_data_length
    logic [15:0] rsub_reg, rsub_next;        // echoed selector
    logic [31:0] rd0_reg, rd0_next;          // reply word 0
    logic [31:0] rd1_reg, rd1_next;          // reply word 1
    logic [31:0] rd2_reg, rd2_next;          // reply word 2

    // hours counter
    logic [31:0] hours_reg, hours_next;      // operating hours
    logic        preset;                     // hours load this cycle

    // sensor side
    logic [NUM_SENSORS-1:0]  clr_vec;        // per-sensor reset pulse
    logic [NUM_SENSORS-1:0]  rec_vec;        // per-sensor snapshot pulse
    shpr_pkg::shpr_reading_t rd_arr [NUM_SENSORS];
    shpr_pkg::shpr_reading_t rd_sel;         // reading of requested sensor

    // request field views
    logic                i_set;              // set class
    shpr_pkg::shpr_sel_t i_sel;              // parameter select
    logic [7:0]          i_len;              // request length
    logic [7:0]          i_sn;               // sensor number
    logic                sn_ok;              // implemented sensor
    logic                sn_all;             // all-sensor code
    logic [7:0]          cap_byte;           // capability byte

    assign i_set    = req_reg[shpr_pkg::REQ_SET_BIT];
    assign i_sel    = shpr_pkg::shpr_sel_t'(req_reg[shpr_pkg::REQ_SEL_LSB +: 2]);
    assign i_len    = req_reg[shpr_pkg::REQ_LEN_LSB +: 8];
    assign i_sn     = data_reg[7:0];
    assign sn_all   = (i_sn == shpr_pkg::SENSOR_ALL);
    assign sn_ok    = ({24'h000000, i_sn} < 32'(NUM_SENSORS));
    assign cap_byte = {6'h00, HAS_MINMAX, HAS_RECORD};

    // one tracker per sensor
    for (genvar g = 0; g < NUM_SENSORS; g++) begin : g_sens
        shpr_sensor_track #(
            .HAS_MINMAX (HAS_MINMAX),
            .HAS_RECORD (HAS_RECORD)
        ) u_track (
            .core_clk     (core_clk),
            .rstn         (rstn),
            .sample       (sensor_sample[g*16 +: 16]),
            .sample_valid (sensor_sample_valid[g]),
            .clear        (clr_vec[g]),
            .record       (rec_vec[g]),
            .reading      (rd_arr[g])
        );
    end

    // pick the requested sensor
    always_comb begin
        rd_sel = '0;
        for (int i = 0; i < NUM_SENSORS; i++) begin
            if (i_sn == 8'(i)) begin
                rd_sel = rd_arr[i];
            end
        end
    end

    // merge write data by byte lane
    function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    // read mux, unmapped reads zero
    always_comb begin
        case ({avs_address[5:2], 2'b00})
            shpr_pkg::REG_CTRL: rd_mux = shpr_pkg::WORD_RST;
            shpr_pkg::REG_REQ:  rd_mux = req_reg;
            shpr_pkg::REG_SUB:  rd_mux = sub_reg;
            shpr_pkg::REG_DATA: rd_mux = data_reg;
            shpr_pkg::REG_STAT: begin
                rd_mux = shpr_pkg::WORD_RST;
                rd_mux[shpr_pkg::STAT_BUSY_BIT]        = (st_reg != ST_IDLE);
                rd_mux[shpr_pkg::STAT_DONE_BIT]        = done_reg;
                rd_mux[shpr_pkg::STAT_NACK_BIT]        = nack_reg;
                rd_mux[shpr_pkg::STAT_REASON_LSB +: 8] = reason_reg;
                rd_mux[shpr_pkg::STAT_LEN_LSB +: 8]    = rlen_reg;
            end
            shpr_pkg::REG_RSUB: begin
                rd_mux = shpr_pkg::WORD_RST;
                rd_mux[15:0] = rsub_reg;
                rd_mux[shpr_pkg::RSUB_COUNT_LSB +: 8] = shpr_pkg::MSG_COUNT;
            end
            shpr_pkg::REG_RD0:  rd_mux = rd0_reg;
            shpr_pkg::REG_RD1:  rd_mux = rd1_reg;
            shpr_pkg::REG_RD2:  rd_mux = rd2_reg;
            default:            rd_mux = shpr_pkg::WORD_RST;
        endcase
    end

    // bus handshake: one wait cycle, then the access is taken
    always_comb begin
        wait_next  = ~((avs_read | avs_write) & wait_reg);
        rdata_next = (avs_read & wait_reg) ? rd_mux : rdata_reg;
        wr_acc     = avs_write & ~wait_reg;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wait_reg  <= shpr_pkg::WAIT_RST;
            rdata_reg <= shpr_pkg::WORD_RST;
        end else begin
            wait_reg  <= wait_next;
            rdata_reg <= rdata_next;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata    = rdata_reg;

    // request registers, frozen while a command runs
    always_comb begin
        req_next  = req_reg;
        sub_next  = sub_reg;
        data_next = data_reg;
        start     = 1'b0;
        if (wr_acc && st_reg == ST_IDLE) begin
            case ({avs_address[5:2], 2'b00})
                shpr_pkg::REG_REQ:  req_next  = be_merge(req_reg, avs_writedata, avs_byteenable);
                shpr_pkg::REG_SUB:  sub_next  = be_merge(sub_reg, avs_writedata, avs_byteenable);
                shpr_pkg::REG_DATA: data_next = be_merge(data_reg, avs_writedata, avs_byteenable);
                shpr_pkg::REG_CTRL: start = avs_byteenable[0] & avs_writedata[shpr_pkg::CTRL_START_BIT];
                default:            start = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            req_reg  <= shpr_pkg::WORD_RST;
            sub_reg  <= shpr_pkg::WORD_RST;
            data_reg <= shpr_pkg::WORD_RST;
        end else begin
            req_reg  <= req_next;
            sub_reg  <= sub_next;
            data_reg <= data_next;
        end
    end

    // command engine: decode and act, then gather the reply
    always_comb begin
        st_next     = st_reg;
        done_next   = done_reg;
        nack_next   = nack_reg;
        reason_next = reason_reg;
        rlen_next   = rlen_reg;
        rsub_next   = rsub_reg;
        rd0_next    = rd0_reg;
        rd1_next    = rd1_reg;
        rd2_next    = rd2_reg;
        clr_vec     = '0;
        rec_vec     = '0;
        preset      = 1'b0;
        case (st_reg)
            ST_IDLE: begin
                if (start) begin
                    done_next = 1'b0;
                    st_next   = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nack_next   = 1'b0;
                reason_next = shpr_pkg::NACK_NONE;
                rlen_next   = shpr_pkg::LEN_EMPTY;
                rsub_next   = sub_reg[15:0];
                st_next     = ST_REPLY;
                case (i_sel)
                    shpr_pkg::SHPR_SEL_SENSOR: begin
                        rlen_next = shpr_pkg::LEN_SENSOR_RSP;
                        if (i_len != shpr_pkg::LEN_ONE) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_FORMAT;
                        end else if ((sn_all && !i_set) || (!sn_all && !sn_ok)) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_RANGE;
                        end else if (i_set) begin
                            clr_vec = sn_all ? '1 : (NUM_SENSORS'(1) << i_sn);
                        end
                    end
                    shpr_pkg::SHPR_SEL_RECORD: begin
                        if (!i_set || !HAS_RECORD) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_UNSUPP;
                        end else if (i_len != shpr_pkg::LEN_ONE) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_FORMAT;
                        end else if (!sn_all && !sn_ok) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_RANGE;
                        end else begin
                            rec_vec = sn_all ? '1 : (NUM_SENSORS'(1) << i_sn);
                        end
                    end
                    shpr_pkg::SHPR_SEL_HOURS: begin
                        if (i_set) begin
                            if (!HAS_HOURS_SET) begin
                                nack_next   = 1'b1;
                                reason_next = shpr_pkg::NACK_UNSUPP;
                            end else if (i_len != shpr_pkg::LEN_HOURS) begin
                                nack_next   = 1'b1;
                                reason_next = shpr_pkg::NACK_FORMAT;
                            end else begin
                                preset = 1'b1;
                            end
                        end else if (i_len != shpr_pkg::LEN_EMPTY) begin
                            nack_next   = 1'b1;
                            reason_next = shpr_pkg::NACK_FORMAT;
                        end else begin
                            rlen_next = shpr_pkg::LEN_HOURS;
                        end
                    end
                    default: begin
                        nack_next   = 1'b1;
                        reason_next = shpr_pkg::NACK_UNSUPP;
                    end
                endcase
                if (nack_next) begin
                    rlen_next = shpr_pkg::LEN_EMPTY;
                end
            end
            ST_REPLY: begin
                // trackers already hold any reset applied in the previous cycle
                rd0_next = shpr_pkg::WORD_RST;
                rd1_next = shpr_pkg::WORD_RST;
                rd2_next = shpr_pkg::WORD_RST;
                if (!nack_reg && i_sel == shpr_pkg::SHPR_SEL_SENSOR) begin
                    rd0_next[7:0]                        = i_sn;
                    rd0_next[shpr_pkg::RD0_CAP_LSB +: 8] = cap_byte;
                    rd1_next = {rd_sel.present, rd_sel.lowest};
                    rd2_next = {rd_sel.highest, rd_sel.recorded};
                end else if (!nack_reg && i_sel == shpr_pkg::SHPR_SEL_HOURS && !i_set) begin
                    rd1_next = hours_reg;
                end
                done_next = 1'b1;
                st_next   = ST_IDLE;
            end
            default: begin
                st_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_reg     <= ST_IDLE;
            done_reg   <= 1'b0;
            nack_reg   <= 1'b0;
            reason_reg <= shpr_pkg::NACK_NONE;
            rlen_reg   <= shpr_pkg::LEN_EMPTY;
            rsub_reg   <= 16'h0000;
            rd0_reg    <= shpr_pkg::WORD_RST;
            rd1_reg    <= shpr_pkg::WORD_RST;
            rd2_reg    <= shpr_pkg::WORD_RST;
        end else begin
            st_reg     <= st_next;
            done_reg   <= done_next;
            nack_reg   <= nack_next;
            reason_reg <= reason_next;
            rlen_reg   <= rlen_next;
            rsub_reg   <= rsub_next;
            rd0_reg    <= rd0_next;
            rd1_reg    <= rd1_next;
            rd2_reg    <= rd2_next;
        end
    end

    // hours counter: preset wins, ticks stop at the top
    always_comb begin
        hours_next = hours_reg;
        if (preset) begin
            hours_next = data_reg;
        end else if (hour_tick && hours_reg != shpr_pkg::HOURS_MAX) begin
            hours_next = hours_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            hours_reg <= shpr_pkg::WORD_RST;
        end else begin
            hours_reg <= hours_next;
        end
    end

endmodule : shpr_responder

`default_nettype wire

// [bench/shpr_resp_asserts.sv]
`timescale 1ns/1ps
`default_nettype none

// watches the register bus of the responder
module shpr_resp_asserts (
    input wire logic        core_clk,
    input wire logic        rstn,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    logic       rd_ok;  // edge at which read data are taken
    logic [3:0] word;   // decoded word index
    assign rd_ok = avs_read && !avs_waitrequest;
    assign word  = avs_address[5:2];

    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("wait low for more than one cycle");
    wait_answer_a: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("request not answered after one cycle");
    idle_stall_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
        else $error("wait low while idle");
    rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_ok && (word == 4'h0 || word > 4'h8) |-> avs_readdata == 32'h0)
        else $error("control or unmapped word not zero");
    msg_count_a: assert property (rd_ok && word == 4'h5 |-> avs_readdata[23:16] == 8'h00)
        else $error("message count not zero");
    nack_len_a: assert property (rd_ok && word == 4'h4 && avs_readdata[2] |-> avs_readdata[23:16] == 8'h00)
        else $error("refused reply has data");
    reply_len_a: assert property (rd_ok && word == 4'h4 |->
        avs_readdata[23:16] inside {8'h00, 8'h04, 8'h09})
        else $error("reply length illegal");
    cap_bits_a: assert property (rd_ok && word == 4'h6 |-> avs_readdata[15:10] == 6'h00)
        else $error("capability upper bits set");
endmodule : shpr_resp_asserts

bind shpr_responder shpr_resp_asserts chk_u (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

`default_nettype wire

// [bench/shpr_sensor_src.sv]
`timescale 1ns/1ps
`default_nettype none

// sensors and hour meter feeding the responder
module shpr_sensor_src #(
    parameter int NUM_SENSORS = 4
) (
    input  wire logic                      core_clk,
    output logic      [NUM_SENSORS*16-1:0] sensor_sample,
    output logic      [NUM_SENSORS-1:0]    sensor_sample_valid,
    output logic                           hour_tick
);
    initial begin
        sensor_sample       = '0;
        sensor_sample_valid = '0;
        hour_tick           = 1'h0;
    end

    // one-cycle load of a signed reading; lines turn stale afterwards
    task automatic put(input int idx, input logic signed [15:0] v);
        @(posedge core_clk);
        sensor_sample[idx*16+:16] <= v;
        sensor_sample_valid[idx]  <= 1'h1;
        @(posedge core_clk);
        sensor_sample[idx*16+:16] <= ~v;
        sensor_sample_valid       <= '0;
    endtask : put

    // one hour of operation
    task automatic tick();
        @(posedge core_clk);
        hour_tick <= 1'h1;
        @(posedge core_clk);
        hour_tick <= 1'h0;
    endtask : tick
endmodule : shpr_sensor_src

`default_nettype wire

// [bench/sensor_hours_param_responder_test.sv]
`timescale 1ns/1ps
`default_nettype none

module sensor_hours_param_responder_test;
    logic        core_clk;
    logic        rstn;
    logic [5:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [63:0] smp;
    logic [3:0]  smp_v;
    logic        tick;
    logic [31:0] q;   // last read data
    logic [31:0] st;  // status after a command
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    shpr_responder dut_u (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .sensor_sample(smp), .sensor_sample_valid(smp_v), .hour_tick(tick));
    shpr_sensor_src src_u (.core_clk(core_clk), .sensor_sample(smp), .sensor_sample_valid(smp_v), .hour_tick(tick));

    initial begin
        core_clk = 1'h0;
        forever #25 core_clk = ~core_clk;
    end

    // hang guard
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one bus access, held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
        avs_write     <= w;
        avs_read      <= !w;
        avs_address   <= a;
        avs_writedata <= d;
        do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
        q = avs_readdata;
        avs_write <= 1'h0;
        avs_read  <= 1'h0;
        @(posedge core_clk);
    endtask : acc

    task automatic rdw(input logic [5:0] a, input string nm, input logic [31:0] e);
        acc(1'h0, a, 32'h0);
        chk(nm, e, q);
    endtask : rdw

    // request, selector, data, start, then poll for done
    task automatic cmd(input logic s, input logic [1:0] sel, input logic [7:0] len, input logic [31:0] d);
        acc(1'h1, shpr_pkg::REG_REQ, {8'h00, len, 6'h00, sel, 7'h00, s});
        acc(1'h1, shpr_pkg::REG_SUB, 32'h0000_0123);
        acc(1'h1, shpr_pkg::REG_DATA, d);
        acc(1'h1, shpr_pkg::REG_CTRL, 32'h0000_0001);
        do acc(1'h0, shpr_pkg::REG_STAT, 32'h0); while (q[1] !== 1'h1);
        st = q;
    endtask : cmd

    task automatic t_sens();
        src_u.put(1, 16'h0005);
        src_u.put(1, 16'hFFFD);
        src_u.put(1, 16'h000A);
        src_u.put(2, 16'h8001);
        cmd(1'h1, 2'h1, 8'h01, 32'h0000_00FF);
        chk("snapshot stat", 32'h0000_0002, st);
        src_u.put(1, 16'h0007);
        cmd(1'h0, 2'h0, 8'h01, 32'h0000_0001);
        chk("get stat", 32'h0009_0002, st);
        rdw(shpr_pkg::REG_RSUB, "rsub", 32'h0000_0123);
        rdw(shpr_pkg::REG_RD0, "rd0", 32'h0000_0301);
        rdw(shpr_pkg::REG_RD1, "rd1", 32'h0007_FFFD);
        rdw(shpr_pkg::REG_RD2, "rd2", 32'h000A_000A);
        cmd(1'h0, 2'h0, 8'h01, 32'h0000_0002);
        rdw(shpr_pkg::REG_RD2, "rd2 sensor 2", 32'h8001_8001);
        $display("t_sens done");
    endtask : t_sens

    task automatic t_reset();
        cmd(1'h1, 2'h0, 8'h01, 32'h0000_0001);
        chk("reset stat", 32'h0009_0002, st);
        rdw(shpr_pkg::REG_RD1, "reset rd1", 32'h0007_0007);
        rdw(shpr_pkg::REG_RD2, "reset rd2", 32'h0007_0007);
        cmd(1'h1, 2'h0, 8'h01, 32'h0000_00FF);
        chk("reset all stat", 32'h0009_0002, st);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_nack();
        cmd(1'h0, 2'h0, 8'h01, 32'h0000_0004);
        chk("unknown sensor", 32'h0000_0106, st);
        cmd(1'h0, 2'h0, 8'h01, 32'h0000_00FF);
        chk("all on get", 32'h0000_0106, st);
        cmd(1'h0, 2'h0, 8'h02, 32'h0000_0001);
        chk("bad length", 32'h0000_0206, st);
        cmd(1'h0, 2'h3, 8'h00, 32'h0000_0000);
        chk("bad select", 32'h0000_0306, st);
        cmd(1'h0, 2'h1, 8'h01, 32'h0000_0001);
        chk("snapshot get", 32'h0000_0306, st);
        cmd(1'h0, 2'h2, 8'h04, 32'h0000_0000);
        chk("hours get length", 32'h0000_0206, st);
        rdw(6'h3C, "unmapped", 32'h0000_0000);
        $display("t_nack done");
    endtask : t_nack

    task automatic t_hours();
        cmd(1'h1, 2'h2, 8'h04, 32'hFFFF_FFFE);
        chk("preset stat", 32'h0000_0002, st);
        src_u.tick();
        src_u.tick();
        cmd(1'h0, 2'h2, 8'h00, 32'h0000_0000);
        chk("hours stat", 32'h0004_0002, st);
        rdw(shpr_pkg::REG_RD1, "hours", 32'hFFFF_FFFF);
        $display("t_hours done");
    endtask : t_hours

    initial begin
        rstn          = 1'h0;
        avs_read      = 1'h0;
        avs_write     = 1'h0;
        avs_address   = 6'h00;
        avs_writedata = 32'h0;
        repeat (4) @(posedge core_clk);
        rstn <= 1'h1;
        @(posedge core_clk);
        t_sens();
        t_reset();
        t_nack();
        t_hours();
        summarize();
    end
endmodule : sensor_hours_param_responder_test

`default_nettype wire
